// ---- logic/udec_defs.svh ----
/*
 * Constants of the up/down event counter: register byte offsets, field
 * positions and reset values. Assumes a 32-bit APB register bus and one
 * clock for the whole block.
 */
// Functional notes
// - Outputs A and B carry comparator results only once output enable is one.
// - With outputs enabled, comparator A and B drive outputs A and B directly.
// - With output enable zero, outputs A and B follow general-purpose writes.
// - Clearing call enable freezes the interface; counting and comparing go on.
// - Start preset loads into the count on load strobe edge or counting event.
// - Compare A preset becomes active on its strobe edge or a counting event.
// - Presets are 32-bit signed two's-complement values over the full range.
// - Direction inactive: up increments, down decrements; active swaps them.
// - Pulses count only while software gate and hardware gate are both set.
// - Count wraps from maximum to minimum and from minimum to maximum.
`ifndef UDEC_DEFS_SVH
`define UDEC_DEFS_SVH

`define UDEC_ADDR_W        8
`define UDEC_OFF_CTRL      8'h00
`define UDEC_OFF_LOAD      8'h04
`define UDEC_OFF_START     8'h08
`define UDEC_OFF_CMPA_PRE  8'h0c
`define UDEC_OFF_CMPB_PRE  8'h10
`define UDEC_OFF_COUNT     8'h14
`define UDEC_OFF_CMPA      8'h18
`define UDEC_OFF_CMPB      8'h1c
`define UDEC_OFF_STATUS    8'h20
`define UDEC_OFF_MASK      8'h24
`define UDEC_OFF_GPO       8'h28
`define UDEC_OFF_FLAGS     8'h2c

`define UDEC_CTRL_GATE     0
`define UDEC_CTRL_OUT_EN   1
`define UDEC_CTRL_CALL_EN  2
`define UDEC_CTRL_EV_LOAD  3
`define UDEC_CTRL_W        4
`define UDEC_CTRL_RESET    4'h8

`define UDEC_LOAD_COUNT    0
`define UDEC_LOAD_CMPA     1
`define UDEC_LOAD_CMPB     2

`define UDEC_ST_REACH_A    0
`define UDEC_ST_FALL_A     1
`define UDEC_ST_REACH_B    2
`define UDEC_ST_FALL_B     3
`define UDEC_ST_WRAP_UP    4
`define UDEC_ST_WRAP_DN    5
`define UDEC_ST_W          6

`define UDEC_PRESET_RESET  32'h00000000
`define UDEC_CMPA_RESET    32'h7fffffff
`define UDEC_CMPB_RESET    32'h7fffffff

`endif

// ---- logic/udec_pkg.sv ----
/*
 * Types shared by the up/down event counter modules.
 * Assumes the constants of udec_defs.svh are included where needed.
 */
package udec_pkg;

  typedef enum logic [1:0] {
    UDEC_BUS_IDLE,
    UDEC_BUS_ANSWER,
    UDEC_BUS_DONE
  } udec_bus_state_t;

  typedef logic signed [31:0] udec_value_t;

endpackage

// ---- logic/udec_edge.sv ----
/*
 * Rising edge detector for one level that is synchronous to the clock.
 * Assumes the input is already in the clock domain.
 */
`timescale 1ns/1ps
module udec_edge (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic level,
  output wire logic rise
);

  logic prev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;

endmodule

// ---- logic/udec_compare.sv ----
/*
 * One comparator: holds the active comparison value, takes its preset on
 * a load pulse or a counting event, and flags reaching and falling below.
 * Assumes the count and step pulses come from the counter core.
 */
`timescale 1ns/1ps
module udec_compare
  import udec_pkg::*;
#(
  parameter logic [31:0] RESET_VALUE = 32'h7fffffff
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  udec_value_t      preset,
  input  wire logic        load,
  input  wire logic        step_up,
  input  wire logic        step_down,
  input  udec_value_t      count,
  output udec_value_t      active,
  output wire logic        reach,
  output wire logic        fall,
  output wire logic        level
);

  udec_value_t active_minus;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active <= RESET_VALUE;
    end else if (load) begin
      active <= preset;
    end
  end

  // The step that crosses is judged on the old count, so that a reload
  // in the same cycle cannot hide the crossing.
  assign active_minus = active - 32'sh00000001;
  assign reach = step_up & (count == active_minus);
  assign fall  = step_down & (count == active);
  assign level = (count >= active);

endmodule

// ---- logic/udec_core.sv ----
/*
 * Up/down event counter with APB register access. Sensor inputs count up
 * or down under a hardware and a software gate; two comparators drive
 * digital outputs A and B when enabled. Events raise sticky status bits
 * behind a mask onto one level interrupt.
 * Assumes all pins are synchronous to CLK and a standard APB master.
 */
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "udec_defs.svh"
module udec_core
  import udec_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        UP_IN,
  input  wire logic        DOWN_IN,
  input  wire logic        DIR_IN,
  input  wire logic        HW_GATE,
  output logic             DO_A,
  output logic             DO_B,
  output logic             IRQ
);

  udec_bus_state_t         bus_state;
  udec_bus_state_t         next_bus_state;
  logic [`UDEC_CTRL_W-1:0] ctrl;
  logic [2:0]              load_reg;
  logic [2:0]              load_view;
  udec_value_t             start_value_preset;
  udec_value_t             compare_a_preset;
  udec_value_t             compare_b_preset;
  udec_value_t             count;
  udec_value_t             count_view;
  udec_value_t             next_count;
  logic [`UDEC_ST_W-1:0]   status;
  logic [`UDEC_ST_W-1:0]   next_status;
  logic [`UDEC_ST_W-1:0]   mask;
  logic [1:0]              gpo;

  wire logic [`UDEC_ADDR_W-1:0] addr;
  wire logic        addr_ok;
  wire logic        taken;
  wire logic        done;
  wire logic        wr;
  wire logic        rd_status;
  wire logic [31:0] rdata;
  wire logic        count_gate;
  wire logic        call_enable;
  wire logic        call_ok_flag;
  wire logic        out_enable;
  wire logic        up_rise;
  wire logic        down_rise;
  wire logic        inc;
  wire logic        dec;
  wire logic        step_up;
  wire logic        step_down;
  wire logic        set_count_rise;
  wire logic        set_cmpa_rise;
  wire logic        set_cmpb_rise;
  wire logic        counting_event;
  wire logic        event_load;
  wire logic        reach_a;
  wire logic        fall_a;
  wire logic        reach_b;
  wire logic        fall_b;
  wire logic        level_a;
  wire logic        level_b;
  wire logic        wrap_up;
  wire logic        wrap_dn;
  wire logic [`UDEC_ST_W-1:0] events;
  wire logic [`UDEC_ST_W-1:0] status_clr;
  wire logic        next_do_a;
  wire logic        next_do_b;
  wire logic        wr_ctrl;
  wire logic        wr_load;
  wire logic        wr_start;
  wire logic        wr_cmpa;
  wire logic        wr_cmpb;
  wire logic        wr_mask;
  wire logic        wr_gpo;
  udec_value_t      active_a;
  udec_value_t      active_b;

  // Bus decode. The answer comes one cycle into the access phase so that
  // read data is registered and the slave never answers combinationally.
  assign addr    = PADDR[`UDEC_ADDR_W-1:0];
  assign addr_ok = (PADDR[31:`UDEC_ADDR_W] == '0) && (addr[1:0] == 2'b00) &&
                   (addr <= `UDEC_OFF_FLAGS);
  assign taken   = PSEL & PENABLE & (bus_state == UDEC_BUS_IDLE);
  assign done    = PSEL & PENABLE & PREADY;
  assign wr      = done & PWRITE & addr_ok;
  assign rd_status = done & ~PWRITE & (addr == `UDEC_OFF_STATUS);

  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      UDEC_BUS_IDLE: begin
        if (taken) begin
          next_bus_state = UDEC_BUS_ANSWER;
        end
      end
      UDEC_BUS_ANSWER: begin
        next_bus_state = UDEC_BUS_DONE;
      end
      UDEC_BUS_DONE: begin
        next_bus_state = UDEC_BUS_IDLE;
      end
      default: begin
        next_bus_state = UDEC_BUS_IDLE;
      end
    endcase
  end

  assign rdata =
    (addr == `UDEC_OFF_CTRL)     ? {{(32-`UDEC_CTRL_W){1'b0}}, ctrl} :
    (addr == `UDEC_OFF_LOAD)     ? {29'h0, load_reg} :
    (addr == `UDEC_OFF_START)    ? start_value_preset :
    (addr == `UDEC_OFF_CMPA_PRE) ? compare_a_preset :
    (addr == `UDEC_OFF_CMPB_PRE) ? compare_b_preset :
    (addr == `UDEC_OFF_COUNT)    ? count_view :
    (addr == `UDEC_OFF_CMPA)     ? active_a :
    (addr == `UDEC_OFF_CMPB)     ? active_b :
    (addr == `UDEC_OFF_STATUS)   ? {{(32-`UDEC_ST_W){1'b0}}, status} :
    (addr == `UDEC_OFF_MASK)     ? {{(32-`UDEC_ST_W){1'b0}}, mask} :
    (addr == `UDEC_OFF_GPO)      ? {30'h0, gpo} :
    (addr == `UDEC_OFF_FLAGS)    ? {29'h0, level_b, level_a, call_ok_flag} :
    32'h00000000;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      bus_state <= UDEC_BUS_IDLE;
      PREADY    <= 1'b0;
      PSLVERR   <= 1'b0;
      PRDATA    <= 32'h00000000;
    end else begin
      bus_state <= next_bus_state;
      PREADY    <= taken;
      PSLVERR   <= taken & ~addr_ok;
      if (taken) begin
        PRDATA <= addr_ok ? rdata : 32'h00000000;
      end
    end
  end

  // Software-written registers. Writes land on the edge that completes
  // the transfer and never earlier.
  assign wr_ctrl  = wr & (addr == `UDEC_OFF_CTRL);
  assign wr_load  = wr & (addr == `UDEC_OFF_LOAD);
  assign wr_start = wr & (addr == `UDEC_OFF_START);
  assign wr_cmpa  = wr & (addr == `UDEC_OFF_CMPA_PRE);
  assign wr_cmpb  = wr & (addr == `UDEC_OFF_CMPB_PRE);
  assign wr_mask  = wr & (addr == `UDEC_OFF_MASK);
  assign wr_gpo   = wr & (addr == `UDEC_OFF_GPO);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl <= `UDEC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= PWDATA[`UDEC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      load_reg <= 3'h0;
    end else if (wr_load) begin
      load_reg <= PWDATA[2:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      start_value_preset <= `UDEC_PRESET_RESET;
    end else if (wr_start) begin
      start_value_preset <= PWDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      compare_a_preset <= `UDEC_CMPA_RESET;
    end else if (wr_cmpa) begin
      compare_a_preset <= PWDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      compare_b_preset <= `UDEC_CMPB_RESET;
    end else if (wr_cmpb) begin
      compare_b_preset <= PWDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mask <= '0;
    end else if (wr_mask) begin
      mask <= PWDATA[`UDEC_ST_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      gpo <= 2'h0;
    end else if (wr_gpo) begin
      gpo <= PWDATA[1:0];
    end
  end

  assign count_gate   = ctrl[`UDEC_CTRL_GATE];
  assign out_enable   = ctrl[`UDEC_CTRL_OUT_EN];
  assign call_enable  = ctrl[`UDEC_CTRL_CALL_EN];
  assign call_ok_flag = call_enable;

  // The interface view: strobes and the count readback only move while
  // the block call is enabled. Holding the strobe view, rather than
  // gating it, keeps a re-enable from faking a rising edge.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      load_view  <= 3'h0;
      count_view <= 32'sh00000000;
    end else if (call_enable) begin
      load_view  <= load_reg;
      count_view <= next_count;
    end
  end

  udec_edge u_edge_up (
    .clk   (CLK),
    .rst_b (RST_B),
    .level (UP_IN),
    .rise  (up_rise)
  );

  udec_edge u_edge_down (
    .clk   (CLK),
    .rst_b (RST_B),
    .level (DOWN_IN),
    .rise  (down_rise)
  );

  udec_edge u_edge_set_count (
    .clk   (CLK),
    .rst_b (RST_B),
    .level (load_view[`UDEC_LOAD_COUNT]),
    .rise  (set_count_rise)
  );

  udec_edge u_edge_set_cmpa (
    .clk   (CLK),
    .rst_b (RST_B),
    .level (load_view[`UDEC_LOAD_CMPA]),
    .rise  (set_cmpa_rise)
  );

  udec_edge u_edge_set_cmpb (
    .clk   (CLK),
    .rst_b (RST_B),
    .level (load_view[`UDEC_LOAD_CMPB]),
    .rise  (set_cmpb_rise)
  );

  // Gate and direction are taken as they stand at the counting edge; the
  // sensor side keeps them settled around that edge.
  assign inc = (DIR_IN ? down_rise : up_rise) & count_gate & HW_GATE;
  assign dec = (DIR_IN ? up_rise : down_rise) & count_gate & HW_GATE;
  // Coincident up and down edges cancel, which leaves the count as is.
  assign step_up   = inc & ~dec;
  assign step_down = dec & ~inc;

  udec_compare #(
    .RESET_VALUE (`UDEC_CMPA_RESET)
  ) u_cmp_a (
    .clk       (CLK),
    .rst_b     (RST_B),
    .preset    (compare_a_preset),
    .load      (set_cmpa_rise | event_load),
    .step_up   (step_up),
    .step_down (step_down),
    .count     (count),
    .active    (active_a),
    .reach     (reach_a),
    .fall      (fall_a),
    .level     (level_a)
  );

  udec_compare #(
    .RESET_VALUE (`UDEC_CMPB_RESET)
  ) u_cmp_b (
    .clk       (CLK),
    .rst_b     (RST_B),
    .preset    (compare_b_preset),
    .load      (set_cmpb_rise | event_load),
    .step_up   (step_up),
    .step_down (step_down),
    .count     (count),
    .active    (active_b),
    .reach     (reach_b),
    .fall      (fall_b),
    .level     (level_b)
  );

  assign counting_event = reach_a | fall_a | reach_b | fall_b;
  // Loading on an event is the configurable reaction; with it off the
  // presets wait for their strobes.
  assign event_load = counting_event & ctrl[`UDEC_CTRL_EV_LOAD];

  assign wrap_up = step_up & (count == 32'sh7fffffff);
  assign wrap_dn = step_down & (count == 32'sh80000000);

  // Plain two's-complement arithmetic gives the wrap at both limits.
  assign next_count =
    (set_count_rise | event_load) ? start_value_preset :
    step_up   ? count + 32'sh00000001 :
    step_down ? count - 32'sh00000001 :
    count;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      count <= 32'sh00000000;
    end else begin
      count <= next_count;
    end
  end

  // Sticky status: an event in the cycle of the clearing read survives.
  assign events = {wrap_dn, wrap_up, fall_b, reach_b, fall_a, reach_a};
  assign status_clr  = rd_status ? {`UDEC_ST_W{1'b1}} : '0;
  assign next_status = (status & ~status_clr) | events;

  assign next_do_a = out_enable ? level_a : gpo[0];
  assign next_do_b = out_enable ? level_b : gpo[1];

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      status <= '0;
      IRQ    <= 1'b0;
      DO_A   <= 1'b0;
      DO_B   <= 1'b0;
    end else begin
      status <= next_status;
      IRQ    <= |(next_status & mask);
      DO_A   <= next_do_a;
      DO_B   <= next_do_b;
    end
  end

endmodule

// ---- verification/udec_checker.sv ----
/* Port checker for udec_core: APB answer timing and output causes.
   Bound to the core from the bench top file. */
`timescale 1ns/1ps
module udec_checker (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        UP_IN,
  input wire logic        DOWN_IN,
  input wire logic        DIR_IN,
  input wire logic        HW_GATE,
  input wire logic        DO_A,
  input wire logic        DO_B,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire logic acc = PSEL && PENABLE;
  wire logic wr_done = acc && PREADY && PWRITE;
  wire logic bad_addr = (PADDR[31:8] != 24'h0) || (PADDR[7:0] > 8'h2c);
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  property p_ready_time;
    $rose(PENABLE) && PSEL |-> s_answer;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("late ready");
  property p_ready_once;
    PREADY |=> !PREADY;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("long ready");
  property p_ready_cause;
    PREADY |-> acc;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_err_data;
    PREADY && PSLVERR |-> PRDATA == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error data");
  property p_unmapped;
    PREADY && bad_addr |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_do_cause;
    $changed({DO_A, DO_B}) |-> $past(wr_done, 2) || $past(wr_done, 4) ||
      $past(UP_IN, 2) || $past(DOWN_IN, 2);
  endproperty
  a_do_cause: assert property (p_do_cause) else $error("output moved");
  property p_irq_rise;
    $rose(IRQ) |-> $past(wr_done, 2) || $past(UP_IN) || $past(DOWN_IN);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
  property p_irq_fall;
    $fell(IRQ) |-> $past(PREADY);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  property p_reset_quiet;
    $rose(RST_B) |-> !PREADY && !IRQ && !DO_A && !DO_B;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset out");
endmodule

// ---- verification/udec_sensor.sv ----
/* Sensor model: counting pulses, direction and hardware gate lines.
   Driven by task calls from the bench; push-pull lines, never released. */
`timescale 1ns/1ps
module udec_sensor #(
  parameter int SETTLE = 5000
) (
  input  wire logic clk,
  output logic      up_out,
  output logic      dn_out,
  output logic      dir_out,
  output logic      gate_out
);
  initial begin
    up_out = 1'h0;
    dn_out = 1'h0;
    dir_out = 1'h0;
    gate_out = 1'h0;
  end
  // Lines only move inside a quiet span on both sides of any pulse.
  task automatic set_lines(input logic d, input logic g);
    repeat (SETTLE) @(posedge clk);
    dir_out <= d;
    gate_out <= g;
    repeat (SETTLE) @(posedge clk);
  endtask
  task automatic pulse(input logic down);
    @(posedge clk);
    if (down) dn_out <= 1'h1;
    else up_out <= 1'h1;
    @(posedge clk);
    up_out <= 1'h0;
    dn_out <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// ---- verification/udec_tb_top.sv ----
/* Bench top for udec_core: APB tasks, sensor model, directed tests.
   Assumes the register map of udec_defs.svh and a two-cycle APB answer. */
`timescale 1ns/1ps
`include "udec_defs.svh"
bind udec_core udec_checker chk_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .UP_IN(UP_IN),
  .DOWN_IN(DOWN_IN), .DIR_IN(DIR_IN), .HW_GATE(HW_GATE), .DO_A(DO_A),
  .DO_B(DO_B), .IRQ(IRQ));
module udec_tb_top
  import udec_pkg::*;
;
  logic        CLK;
  logic        RST_B;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [31:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, UP_IN, DOWN_IN, DIR_IN, HW_GATE;
  logic        DO_A, DO_B, IRQ;
  int          mismatches = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        er;
  always #10 CLK = ~CLK;
  udec_core dut_u (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .UP_IN(UP_IN), .DOWN_IN(DOWN_IN),
    .DIR_IN(DIR_IN), .HW_GATE(HW_GATE), .DO_A(DO_A), .DO_B(DO_B),
    .IRQ(IRQ));
  udec_sensor #(.SETTLE(20)) sens_u (.clk(CLK), .up_out(UP_IN),
    .dn_out(DOWN_IN), .dir_out(DIR_IN), .gate_out(HW_GATE));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= {24'h0, a};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic outs(input string nm, input logic [1:0] e);
    chk(nm, {30'h0, DO_B, DO_A}, {30'h0, e});
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge CLK);
    mismatches++;
    print_verdict();
  end
  initial begin
    CLK = 1'h0;
    RST_B <= 1'h0;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    PWRITE <= 1'h0;
    PADDR <= 32'h0;
    PWDATA <= 32'h0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'h1;
    rdchk("ctrl", `UDEC_OFF_CTRL, 32'h8);
    rdchk("cmpa", `UDEC_OFF_CMPA, 32'h7fffffff);
    rdchk("count", `UDEC_OFF_COUNT, 32'h0);
    apb(1'h0, 8'h30, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    chk("errdata", rd, 32'h0);
    $display("test reset done");
    wr(`UDEC_OFF_CTRL, 32'h5);
    wr(`UDEC_OFF_MASK, 32'h10);
    wr(`UDEC_OFF_START, 32'h7ffffffe);
    wr(`UDEC_OFF_LOAD, 32'h1);
    wr(`UDEC_OFF_LOAD, 32'h0);
    rdchk("preset", `UDEC_OFF_COUNT, 32'h7ffffffe);
    sens_u.set_lines(1'h0, 1'h1);
    sens_u.pulse(1'h0);
    sens_u.pulse(1'h0);
    sens_u.pulse(1'h1);
    rdchk("wrap", `UDEC_OFF_COUNT, 32'h7fffffff);
    chk("irq", {31'h0, IRQ}, 32'h1);
    rdchk("status", `UDEC_OFF_STATUS, 32'h35);
    rdchk("cleared", `UDEC_OFF_STATUS, 32'h0);
    chk("irqlow", {31'h0, IRQ}, 32'h0);
    $display("test count done");
    sens_u.set_lines(1'h1, 1'h1);
    sens_u.pulse(1'h0);
    rdchk("dir", `UDEC_OFF_COUNT, 32'h7ffffffe);
    sens_u.set_lines(1'h0, 1'h0);
    sens_u.pulse(1'h0);
    sens_u.set_lines(1'h0, 1'h1);
    wr(`UDEC_OFF_CTRL, 32'h4);
    sens_u.pulse(1'h0);
    rdchk("gate", `UDEC_OFF_COUNT, 32'h7ffffffe);
    $display("test gates done");
    wr(`UDEC_OFF_GPO, 32'h3);
    wr(`UDEC_OFF_CTRL, 32'h5);
    repeat (2) @(posedge CLK);
    outs("gpo", 2'h3);
    wr(`UDEC_OFF_CTRL, 32'h7);
    repeat (2) @(posedge CLK);
    outs("enabled", 2'h0);
    wr(`UDEC_OFF_CMPA_PRE, 32'h80000000);
    wr(`UDEC_OFF_LOAD, 32'h2);
    wr(`UDEC_OFF_LOAD, 32'h0);
    rdchk("cmpload", `UDEC_OFF_CMPA, 32'h80000000);
    outs("cmpout", 2'h1);
    $display("test outputs done");
    wr(`UDEC_OFF_CTRL, 32'h3);
    wr(`UDEC_OFF_START, 32'h5);
    wr(`UDEC_OFF_LOAD, 32'h1);
    wr(`UDEC_OFF_LOAD, 32'h0);
    sens_u.pulse(1'h0);
    outs("frozen", 2'h3);
    wr(`UDEC_OFF_CTRL, 32'h7);
    rdchk("view", `UDEC_OFF_COUNT, 32'h7fffffff);
    $display("test callen done");
    wr(`UDEC_OFF_CMPA_PRE, 32'h3);
    wr(`UDEC_OFF_CTRL, 32'hf);
    sens_u.pulse(1'h1);
    rdchk("evcount", `UDEC_OFF_COUNT, 32'h5);
    rdchk("evcmpa", `UDEC_OFF_CMPA, 32'h3);
    outs("evout", 2'h1);
    $display("test event done");
    print_verdict();
  end
endmodule
